//--- inc/serial_audio_out_pin_pkg.sv
// Constants, types and encodings shared by the serial audio transmitter
package serial_audio_out_pin_pkg;
   localparam int unsigned WORD_W     = 32;
   localparam int unsigned IDX_W      = 16;
   localparam int unsigned ACC_W      = 32;
   localparam int unsigned UI_CNT_W   = 6;
   localparam logic [5:0]  UI_ENC_LAST = 6'h3F;
   localparam logic [5:0]  UI_TRN_LAST = 6'h1F;
   localparam logic [5:0]  UI_PRE_END  = 6'h08;
   localparam logic [5:0]  UI_ZERO     = 6'h00;
   localparam int unsigned PAR_LO     = 4;
   localparam int unsigned PAR_HI     = 30;
   localparam int unsigned PAR_SLOT   = 31;
   localparam logic [3:0]  PRE_CODE_B = 4'h0;
   localparam logic [3:0]  PRE_CODE_M = 4'h1;
   localparam logic [3:0]  PRE_CODE_W = 4'h2;
   // Patterns assume the line sits low before the preamble
   localparam logic [7:0]  PRE_PAT_B  = 8'hE8;
   localparam logic [7:0]  PRE_PAT_M  = 8'hE2;
   localparam logic [7:0]  PRE_PAT_W  = 8'hE4;
   localparam logic [15:0] IDX_ONE    = 16'h0001;
   localparam logic [1:0]  BYTE_SHIFT = 2'h0;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_RUN} tx_state_t;
endpackage

//--- design/ui_rate_synth.sv
// Phase-accumulating rate synthesizer giving one-cycle unit-interval enables
`timescale 1ns/1ns
module ui_rate_synth (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        run,
   input  wire logic [31:0] frequency,
   output logic             ui_tick
);
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic        tick_reg;
   logic        tick_next;

   // Carry out of the accumulator is the enable; rate = clk * freq / 2^32
   always_comb begin
      logic [32:0] sum;
      sum       = {1'b0, acc_reg} + {1'b0, frequency};
      acc_next  = run ? sum[31:0] : '0;
      tick_next = run & sum[32];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         acc_reg  <= '0;
         tick_reg <= 1'b0;
      end else begin
         acc_reg  <= acc_next;
         tick_reg <= tick_next;
      end
   end

   assign ui_tick = tick_reg;

   property p_idle_quiet;
      @(posedge clk_sys) disable iff (!rst_n)
      !run |=> !ui_tick;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("Tick while synthesizer idle");
endmodule

//--- design/iec958_serial_transmitter.sv
// Two-buffer serial audio transmitter with preamble, parity and bi-phase mark coding
`timescale 1ns/1ns
module iec958_serial_transmitter (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        trans_enable,
   input  wire logic        encoded_mode,
   input  wire logic        msb_first,
   input  wire logic [31:0] frequency,
   input  wire logic [31:0] buf_base1,
   input  wire logic [31:0] buf_base2,
   input  wire logic [15:0] buf_size_words,
   output logic             fetch_req,
   output logic [31:0]      fetch_addr,
   input  wire logic        fetch_ack,
   input  wire logic [31:0] fetch_data,
   input  wire logic        first_buffer_refill_ack,
   input  wire logic        second_buffer_refill_ack,
   input  wire logic        underrun_clear_bit,
   output logic             first_buffer_drained_flag,
   output logic             second_buffer_drained_flag,
   output logic             underrun_flag,
   output logic             active_buffer,
   output logic             serial_audio_out_pin
);
   serial_audio_out_pin_pkg::tx_state_t state_reg;
   serial_audio_out_pin_pkg::tx_state_t state_next;
   logic        enc_reg;
   logic        enc_next;
   logic        msb_reg;
   logic        msb_next;
   logic [5:0]  ui_cnt_reg;
   logic [5:0]  ui_cnt_next;
   logic [31:0] word_reg;
   logic [31:0] word_next;
   logic [31:0] hold_reg;
   logic [31:0] hold_next;
   logic        hold_valid_reg;
   logic        hold_valid_next;
   logic        out_reg;
   logic        out_next;
   logic        req_reg;
   logic        req_next;
   logic [31:0] addr_reg;
   logic [31:0] addr_next;
   logic        buf_sel_reg;
   logic        buf_sel_next;
   logic [15:0] idx_reg;
   logic [15:0] idx_next;
   logic [1:0]  drained_reg;
   logic [1:0]  drained_next;
   logic        udr_reg;
   logic        udr_next;
   logic        ui_tick;
   logic        running;
   logic        frame_end;
   logic        last_word;
   logic        drain_event;
   logic        udr_event;
   logic [1:0]  refill_ack;
   logic [5:0]  ui_last;

   // Preamble code to its eight-state violation pattern
   function automatic logic [7:0] preamble_pattern(input logic [3:0] code);
      logic [7:0] pat;
      pat = serial_audio_out_pin_pkg::PRE_PAT_B;
      if (code == serial_audio_out_pin_pkg::PRE_CODE_M) begin
         pat = serial_audio_out_pin_pkg::PRE_PAT_M;
      end else if (code == serial_audio_out_pin_pkg::PRE_CODE_W) begin
         pat = serial_audio_out_pin_pkg::PRE_PAT_W;
      end
      return pat;
   endfunction

   // Even parity over the payload slots, so the whole sub-frame ends low
   function automatic logic payload_parity(input logic [31:0] w);
      return ^w[serial_audio_out_pin_pkg::PAR_HI:serial_audio_out_pin_pkg::PAR_LO];
   endfunction

   ui_rate_synth u_rate (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .run       (running),
      .frequency (frequency),
      .ui_tick   (ui_tick)
   );

   assign running    = (state_reg != serial_audio_out_pin_pkg::TX_IDLE);
   assign ui_last    = enc_reg ? serial_audio_out_pin_pkg::UI_ENC_LAST : serial_audio_out_pin_pkg::UI_TRN_LAST;
   assign frame_end  = (state_reg == serial_audio_out_pin_pkg::TX_RUN) && ui_tick && (ui_cnt_reg == ui_last);
   assign refill_ack = {second_buffer_refill_ack, first_buffer_refill_ack};

   // Mode, sequencing and the serial shifter
   always_comb begin
      logic [5:0] pos;
      logic [4:0] sel;
      logic [7:0] pat;
      pos        = ui_cnt_reg;
      sel        = '0;
      pat        = '0;
      state_next = state_reg;
      enc_next   = enc_reg;
      msb_next   = msb_reg;
      ui_cnt_next = ui_cnt_reg;
      word_next  = word_reg;
      out_next   = out_reg;
      case (state_reg)
         serial_audio_out_pin_pkg::TX_IDLE: begin
            // Mode is sampled only here so a running stream never changes format
            enc_next    = encoded_mode;
            msb_next    = msb_first;
            ui_cnt_next = serial_audio_out_pin_pkg::UI_ZERO;
            out_next    = 1'b0;
            if (trans_enable) begin
               state_next = serial_audio_out_pin_pkg::TX_START;
            end
         end
         serial_audio_out_pin_pkg::TX_START: begin
            ui_cnt_next = ui_last;
            if (hold_valid_reg) begin
               state_next = serial_audio_out_pin_pkg::TX_RUN;
            end
         end
         default: begin
            if (ui_tick) begin
               pos = (ui_cnt_reg == ui_last) ? serial_audio_out_pin_pkg::UI_ZERO : ui_cnt_reg + 6'h01;
               ui_cnt_next = pos;
               if (frame_end) begin
                  if (enc_reg) begin
                     // Slot 31 is replaced by generated parity
                     word_next = {payload_parity(hold_reg), hold_reg[30:0]};
                  end else begin
                     word_next = hold_reg;
                  end
               end
               if (enc_reg) begin
                  if (pos < serial_audio_out_pin_pkg::UI_PRE_END) begin
                     pat      = preamble_pattern(word_next[3:0]);
                     out_next = pat[3'h7 - pos[2:0]];
                  end else if (!pos[0]) begin
                     out_next = ~out_reg;
                  end else begin
                     out_next = out_reg ^ word_next[pos[5:1]];
                  end
               end else begin
                  sel      = msb_reg ? 5'h1F - pos[4:0] : pos[4:0];
                  out_next = word_next[sel];
               end
            end
         end
      endcase
      if (!trans_enable) begin
         state_next = serial_audio_out_pin_pkg::TX_IDLE;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         state_reg  <= serial_audio_out_pin_pkg::TX_IDLE;
         enc_reg    <= 1'b1;
         msb_reg    <= 1'b0;
         ui_cnt_reg <= serial_audio_out_pin_pkg::UI_ZERO;
         word_reg   <= '0;
         out_reg    <= 1'b0;
      end else begin
         state_reg  <= state_next;
         enc_reg    <= enc_next;
         msb_reg    <= msb_next;
         ui_cnt_reg <= ui_cnt_next;
         word_reg   <= word_next;
         out_reg    <= out_next;
      end
   end

   assign last_word   = (idx_reg == buf_size_words - serial_audio_out_pin_pkg::IDX_ONE);
   assign drain_event = req_reg && fetch_ack && last_word;
   // Switching into a buffer software has not refilled is an underrun
   assign udr_event   = drain_event && drained_reg[~buf_sel_reg] && !refill_ack[~buf_sel_reg];

   // Word fetching, buffer alternation and status flags
   always_comb begin
      logic [31:0] base;
      base            = buf_sel_reg ? buf_base2 : buf_base1;
      hold_next       = hold_reg;
      hold_valid_next = hold_valid_reg;
      req_next        = req_reg;
      addr_next       = addr_reg;
      buf_sel_next    = buf_sel_reg;
      idx_next        = idx_reg;
      if (frame_end) begin
         hold_valid_next = 1'b0;
      end
      if (req_reg && fetch_ack) begin
         hold_next       = fetch_data;
         hold_valid_next = 1'b1;
         req_next        = 1'b0;
         if (last_word) begin
            buf_sel_next = ~buf_sel_reg;
            idx_next     = '0;
         end else begin
            idx_next = idx_reg + serial_audio_out_pin_pkg::IDX_ONE;
         end
      end else if (running && !req_reg && !hold_valid_reg) begin
         req_next  = 1'b1;
         addr_next = base + {14'h0000, idx_reg, serial_audio_out_pin_pkg::BYTE_SHIFT};
      end
      if (!running) begin
         hold_valid_next = 1'b0;
         req_next        = 1'b0;
         buf_sel_next    = 1'b0;
         idx_next        = '0;
      end
      // Set wins over a same-cycle acknowledge
      drained_next = drained_reg & ~refill_ack;
      if (drain_event) begin
         drained_next[buf_sel_reg] = 1'b1;
      end
      udr_next = (udr_reg && !underrun_clear_bit) || udr_event;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         hold_reg       <= '0;
         hold_valid_reg <= 1'b0;
         req_reg        <= 1'b0;
         addr_reg       <= '0;
         buf_sel_reg    <= 1'b0;
         idx_reg        <= '0;
         drained_reg    <= '0;
         udr_reg        <= 1'b0;
      end else begin
         hold_reg       <= hold_next;
         hold_valid_reg <= hold_valid_next;
         req_reg        <= req_next;
         addr_reg       <= addr_next;
         buf_sel_reg    <= buf_sel_next;
         idx_reg        <= idx_next;
         drained_reg    <= drained_next;
         udr_reg        <= udr_next;
      end
   end

   assign fetch_req                  = req_reg;
   assign fetch_addr                 = addr_reg;
   assign first_buffer_drained_flag  = drained_reg[0];
   assign second_buffer_drained_flag = drained_reg[1];
   assign underrun_flag              = udr_reg;
   assign active_buffer              = buf_sel_reg;
   assign serial_audio_out_pin       = out_reg;

   property p_enc_length;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == serial_audio_out_pin_pkg::TX_RUN && enc_reg && ui_tick && ui_cnt_reg == 6'h1F && trans_enable)
         |=> ui_cnt_reg == 6'h20;
   endproperty
   a_enc_length: assert property (p_enc_length) else $error("Sub-frame shorter than 64 UI");

   property p_trn_length;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == serial_audio_out_pin_pkg::TX_RUN && !enc_reg && ui_tick && ui_cnt_reg == 6'h1F && trans_enable)
         |=> ui_cnt_reg == 6'h00 && word_reg == $past(hold_reg);
   endproperty
   a_trn_length: assert property (p_trn_length) else $error("Transparent word not 32 UI");

   property p_cell_start;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == serial_audio_out_pin_pkg::TX_RUN && enc_reg && ui_tick && trans_enable)
         |=> (ui_cnt_reg < 6'h08 || ui_cnt_reg[0] || out_reg != $past(out_reg));
   endproperty
   a_cell_start: assert property (p_cell_start) else $error("Cell did not open with a change");

   property p_cell_half;
      @(posedge clk_sys) disable iff (!rst_n)
      (state_reg == serial_audio_out_pin_pkg::TX_RUN && enc_reg && ui_tick && trans_enable)
         |=> (!ui_cnt_reg[0] || ui_cnt_reg < 6'h08
              || out_reg == ($past(out_reg) ^ word_reg[ui_cnt_reg[5:1]]));
   endproperty
   a_cell_half: assert property (p_cell_half) else $error("Second half of cell wrong");

   property p_pre_rise;
      @(posedge clk_sys) disable iff (!rst_n)
      (frame_end && enc_reg && trans_enable) |=> out_reg && !$past(out_reg) ##1 1'b1;
   endproperty
   a_pre_rise: assert property (p_pre_rise) else $error("Preamble without rising edge");

   property p_parity;
      @(posedge clk_sys) disable iff (!rst_n)
      (frame_end && enc_reg && trans_enable) |=> (^word_reg[31:4]) == 1'b0;
   endproperty
   a_parity: assert property (p_parity) else $error("Odd parity in sub-frame");

   property p_drain_flag;
      @(posedge clk_sys) disable iff (!rst_n)
      drain_event |=> drained_reg[$past(buf_sel_reg)] && buf_sel_reg != $past(buf_sel_reg);
   endproperty
   a_drain_flag: assert property (p_drain_flag) else $error("Drain not flagged or no switch");

   property p_ack_clear;
      @(posedge clk_sys) disable iff (!rst_n)
      (first_buffer_refill_ack && !(drain_event && !buf_sel_reg)) |=> !first_buffer_drained_flag;
   endproperty
   a_ack_clear: assert property (p_ack_clear) else $error("Acknowledge did not clear flag");

   property p_udr_sticky;
      @(posedge clk_sys) disable iff (!rst_n)
      (udr_event || (underrun_flag && !underrun_clear_bit)) |=> underrun_flag [*1];
   endproperty
   a_udr_sticky: assert property (p_udr_sticky) else $error("Underrun flag lost");
endmodule

//--- sim/fetch_memory_model.sv
// Descriptor store answering the transmitter's word fetch port
`timescale 1ns/1ns
module fetch_memory_model (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic        fetch_req,
   input  wire logic [31:0] fetch_addr,
   input  wire logic        stall,
   input  wire logic [31:0] salt,
   output logic             fetch_ack,
   output logic [31:0]      fetch_data
);
   function automatic logic [31:0] word_at(input logic [31:0] a);
      logic [31:0] w;
      w = (a * 32'h9E3779B1) ^ salt;
      // 24-bit sample with its MSB on slot 28, low bits reaching the aux slots
      w[28:5] = w[31:8];
      if (a[2]) w[3:0] = serial_audio_out_pin_pkg::PRE_CODE_W;
      else if (a[4:3] == 2'h0) w[3:0] = serial_audio_out_pin_pkg::PRE_CODE_B;
      else w[3:0] = serial_audio_out_pin_pkg::PRE_CODE_M;
      // Leading one lets the bench find the first bit in raw mode
      if (a == 32'h0) w[31] = 1'b1;
      if (a == 32'h100) w[0] = 1'b1;
      return w;
   endfunction

   always @(posedge clk_sys) begin
      if (!rst_n) begin
         fetch_ack <= 1'b0;
         fetch_data <= 32'h0;
      end else if (fetch_req && !fetch_ack && !stall) begin
         fetch_ack <= 1'b1;
         fetch_data <= word_at(fetch_addr);
      end else begin
         fetch_ack <= 1'b0;
         // Released bus alternates between the inverted and the true last word
         fetch_data <= ~fetch_data;
      end
   end
endmodule

//--- sim/tb_top.sv
// Self-checking bench for the serial audio transmitter
`timescale 1ns/1ns
module tb_top;
   logic        clk_sys, rst_n, trans_enable, encoded_mode, msb_first, stall, exp_buf;
   logic [31:0] frequency, buf_base1, buf_base2, salt, seed, fetch_addr, fetch_data;
   logic [15:0] buf_size_words;
   logic        fetch_req, fetch_ack, ack1, ack2, udr_clr, flag1, flag2, udr, act, pin;
   int          n_errors, n_tests, n_acks, exp_idx;
   logic [31:0] word_q[$];

   iec958_serial_transmitter u_iec958_serial_transmitter (.clk_sys(clk_sys), .rst_n(rst_n),
      .trans_enable(trans_enable), .encoded_mode(encoded_mode), .msb_first(msb_first),
      .frequency(frequency), .buf_base1(buf_base1), .buf_base2(buf_base2),
      .buf_size_words(buf_size_words), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .fetch_ack(fetch_ack), .fetch_data(fetch_data), .first_buffer_refill_ack(ack1),
      .second_buffer_refill_ack(ack2), .underrun_clear_bit(udr_clr),
      .first_buffer_drained_flag(flag1), .second_buffer_drained_flag(flag2),
      .underrun_flag(udr), .active_buffer(act), .serial_audio_out_pin(pin));

   fetch_memory_model u_fetch_memory_model (.clk_sys(clk_sys), .rst_n(rst_n),
      .fetch_req(fetch_req), .fetch_addr(fetch_addr), .stall(stall), .salt(salt),
      .fetch_ack(fetch_ack), .fetch_data(fetch_data));

   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) #1 stall = 1'($random(seed));

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // Sampled mid-cycle so the handshake is settled, not racing the edge
   always @(negedge clk_sys) begin
      if (rst_n && fetch_req && fetch_ack) begin
         check({32'h0, fetch_addr}, {32'h0, (exp_buf ? buf_base2 : buf_base1) + 32'(4 * exp_idx)});
         word_q.push_back(fetch_data);
         n_acks++;
         exp_idx++;
         if (exp_idx == int'(buf_size_words)) begin
            exp_idx = 0;
            exp_buf = ~exp_buf;
         end
      end
   end

   function automatic logic [63:0] enc_frame(input logic [31:0] w);
      logic [63:0] r;
      logic        lvl;
      logic        b;
      r = 64'h0;
      case (w[3:0])
         serial_audio_out_pin_pkg::PRE_CODE_M: r[63:56] = serial_audio_out_pin_pkg::PRE_PAT_M;
         serial_audio_out_pin_pkg::PRE_CODE_W: r[63:56] = serial_audio_out_pin_pkg::PRE_PAT_W;
         default: r[63:56] = serial_audio_out_pin_pkg::PRE_PAT_B;
      endcase
      lvl = r[56];
      for (int k = 4; k < 32; k++) begin
         b = (k == 31) ? ^w[30:4] : w[k];
         lvl = ~lvl;
         r[63 - 2 * k] = lvl;
         lvl = lvl ^ b;
         r[62 - 2 * k] = lvl;
      end
      return r;
   endfunction

   // One interval lasts four clocks at the chosen rate word
   task sample_ui(input int n, output logic [63:0] v);
      v = 64'h0;
      for (int i = 0; i < n; i++) begin
         v[n - 1 - i] = pin;
         repeat (4) @(posedge clk_sys);
         #1;
      end
   endtask

   task run(input logic enc, input logic msb, input logic [31:0] b1, input int n);
      logic [63:0] v;
      logic [31:0] w;
      int          k;
      word_q.delete();
      exp_idx = 0;
      exp_buf = 1'b0;
      buf_base1 = b1;
      encoded_mode = enc;
      msb_first = msb;
      trans_enable = 1'b1;
      for (k = 0; k < 2000 && pin !== 1'b1; k++) begin
         @(posedge clk_sys);
         #1;
      end
      check({63'h0, pin}, 64'h1);
      for (int i = 0; i < n; i++) begin
         sample_ui(enc ? 64 : 32, v);
         w = (word_q.size() > 0) ? word_q.pop_front() : 32'h0;
         if (enc)
            check(v, enc_frame(w));
         else
            check(v, {32'h0, msb ? w : {<<{w}}});
      end
      trans_enable = 1'b0;
      repeat (2) @(posedge clk_sys);
      #1;
      check({62'h0, pin, fetch_req}, 64'h0);
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(posedge clk_sys);
      #1;
      s = 1'b0;
   endtask

   task flag_seq;
      wait (n_acks == 4);
      @(posedge clk_sys);
      #1;
      check({62'h0, flag1, act}, 64'h3);
      wait (n_acks == 8);
      @(posedge clk_sys);
      #1;
      check({61'h0, flag1, flag2, udr}, 64'h7);
      pulse(ack1);
      check({62'h0, flag1, udr}, 64'h1);
      pulse(udr_clr);
      check({63'h0, udr}, 64'h0);
      pulse(ack2);
      check({63'h0, flag2}, 64'h0);
   endtask

   initial begin
      #400000;
      n_errors++;
      $display("BAD t=%0t watchdog expired", $time);
      end_of_test;
   end

   initial begin
      seed = 32'hDCEF;
      {clk_sys, rst_n, trans_enable, encoded_mode, msb_first, stall} = 6'h00;
      {ack1, ack2, udr_clr, exp_buf} = 4'h0;
      {n_errors, n_tests, n_acks, exp_idx} = {4{32'h0}};
      frequency = 32'h40000000;
      buf_base1 = 32'h200;
      buf_base2 = 32'h300;
      buf_size_words = 16'h0004;
      salt = $random(seed);
      repeat (4) @(posedge clk_sys);
      #1;
      rst_n = 1'b1;
      check({58'h0, fetch_req, flag1, flag2, udr, act, pin}, 64'h0);
      fork
         run(1'b1, 1'b0, 32'h200, 12);
         flag_seq;
      join
      run(1'b0, 1'b1, 32'h0, 6);
      run(1'b0, 1'b0, 32'h100, 6);
      end_of_test;
   end
endmodule
